/* File: rtl/ccac_map.svh */
`ifndef CCAC_MAP_SVH
`define CCAC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CCAC_OFF_STATUS 6'h01
`define CCAC_OFF_CTRL 6'h08
`define CCAC_OFF_THRES 6'h09

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCAC_BIT_DONE 7
`define CCAC_BIT_IDLE 6
`define CCAC_BIT_START 7
`define CCAC_MODE_HI 6
`define CCAC_MODE_LO 5
`define CCAC_CHAN_HI 4
`define CCAC_CHAN_LO 0
`define CCAC_THR_HI 3
`define CCAC_THR_LO 0
`define CCAC_RSV_HI 7
`define CCAC_RSV_LO 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCAC_RST_MODE 2'h1
`define CCAC_RST_CHAN 5'h0B
`define CCAC_RST_THR 4'h7
`define CCAC_RST_RSV 4'hC

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCAC_CLK_NS 25
`define CCAC_SYM8_NS 128000
`define CCAC_RESULT_MAX_NS 180000
`define CCAC_SYM8_CYCLES \
    ((`CCAC_SYM8_NS + `CCAC_CLK_NS - 1) / `CCAC_CLK_NS)

`endif

/* File: rtl/ccac_pkg.sv */
package ccac_pkg;

    typedef enum logic [1:0] {
        CCAC_MODE_CS_OR_ED = 2'h0,
        CCAC_MODE_ED = 2'h1,
        CCAC_MODE_CS = 2'h2,
        CCAC_MODE_CS_AND_ED = 2'h3
    } ccac_mode_t;

    typedef enum logic [1:0] {
        CCAC_ST_IDLE = 2'h0,
        CCAC_ST_MANUAL = 2'h1,
        CCAC_ST_WAIT_AUTO = 2'h2
    } ccac_state_t;

endpackage

/* File: rtl/ccac_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// fixed-length measurement window
// ----------------------------------------------------------------
module ccac_timer #(
    parameter int unsigned COUNT = 5120
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic abort,
    output logic running,
    output logic done
);
    import ccac_pkg::*;

    localparam int unsigned CW = $clog2(COUNT + 1);

    generate
        if (COUNT < 2)
        begin : g_bad_count
            $error("ccac_timer: COUNT must be at least 2");
        end
    endgenerate

    logic [CW-1:0] count;
    wire last = running && (count == CW'(1));

    // start beats abort, so a restart never loses its window
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= last && !start && !abort;
            if (start)
            begin
                count <= CW'(COUNT);
                running <= 1'b1;
            end
            else if (abort || last)
            begin
                count <= '0;
                running <= 1'b0;
            end
            else if (running)
            begin
                count <= count - CW'(1);
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/ccac_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccac_map.svh"

module ccac_ctrl #(
    parameter int unsigned SYM8_CYCLES = `CCAC_SYM8_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] trx_state_in,
    input wire logic rx_listen,
    input wire logic rx_busy,
    input wire logic shr_detected,
    input wire logic carrier_detect,
    input wire logic [7:0] energy_level,
    output logic [4:0] channel_select,
    output ccac_pkg::ccac_mode_t assess_mode_select,
    output logic assess_end_irq
);
    import ccac_pkg::*;

    localparam int unsigned MAX_CYCLES =
        `CCAC_RESULT_MAX_NS / `CCAC_CLK_NS;

    generate
        if (SYM8_CYCLES + 3 > MAX_CYCLES)
        begin : g_bad_window
            $error("ccac_ctrl: window too long for result deadline");
        end
    endgenerate

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [3:0] energy_threshold_level;
    logic [3:0] thres_reserved;
    logic assess_complete_flag;
    logic channel_idle_flag;
    ccac_state_t state;
    ccac_state_t next_state;
    logic frame_auto_used;
    logic auto_energy;
    logic man_energy;
    logic man_carrier;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == `CCAC_OFF_CTRL);
    wire wr_thres = reg_wr && (reg_addr == `CCAC_OFF_THRES);
    // status offset has no write path at all
    wire assess_start_bit = reg_wdata[`CCAC_BIT_START];
    wire req = wr_ctrl && assess_start_bit;

    // power is given in dB above the sensitivity base value
    wire [7:0] thr_db = {3'h0, energy_threshold_level, 1'b0};
    wire energy_above = energy_level > thr_db;

    // ------------------------------------------------------------
    // measurement windows
    // ------------------------------------------------------------
    wire auto_start = shr_detected && rx_busy && !frame_auto_used;
    wire auto_running;
    wire auto_done;
    wire man_start = req && rx_listen;
    wire man_running;
    wire man_done;

    ccac_timer #(
        .COUNT(SYM8_CYCLES)
    ) u_auto_win (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(auto_start),
        .abort(!rx_busy),
        .running(auto_running),
        .done(auto_done)
    );

    ccac_timer #(
        .COUNT(SYM8_CYCLES)
    ) u_man_win (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(man_start),
        .abort(!rx_listen),
        .running(man_running),
        .done(man_done)
    );

    // ------------------------------------------------------------
    // channel decision
    // ------------------------------------------------------------
    function automatic logic busy_of(ccac_mode_t m, logic ed, logic cs);
        logic b;
        b = 1'b0;
        case (m)
            CCAC_MODE_CS_OR_ED: b = ed || cs;
            CCAC_MODE_ED: b = ed;
            CCAC_MODE_CS: b = cs;
            CCAC_MODE_CS_AND_ED: b = ed && cs;
            default: b = 1'b1;
        endcase
        return b;
    endfunction

    logic fin;
    logic fin_idle;

    always_comb
    begin
        next_state = state;
        fin = 1'b0;
        fin_idle = 1'b0;
        if (req)
        begin
            if (rx_listen)
            begin
                next_state = CCAC_ST_MANUAL;
            end
            else if (rx_busy)
            begin
                if (assess_mode_select != CCAC_MODE_CS && auto_running)
                begin
                    next_state = CCAC_ST_WAIT_AUTO;
                end
                else
                begin
                    // energy part uses the frame's finished window
                    next_state = CCAC_ST_IDLE;
                    fin = 1'b1;
                    fin_idle = !busy_of(assess_mode_select, auto_energy,
                        carrier_detect);
                end
            end
            else
            begin
                // nothing measured, reported busy
                next_state = CCAC_ST_IDLE;
                fin = 1'b1;
                fin_idle = 1'b0;
            end
        end
        else
        begin
            case (state)
                CCAC_ST_IDLE:
                begin
                    next_state = CCAC_ST_IDLE;
                end
                CCAC_ST_MANUAL:
                begin
                    if (man_done || !man_running)
                    begin
                        next_state = CCAC_ST_IDLE;
                        fin = 1'b1;
                        fin_idle = man_done && !busy_of(assess_mode_select,
                            man_energy || energy_above,
                            man_carrier || carrier_detect);
                    end
                end
                CCAC_ST_WAIT_AUTO:
                begin
                    if (auto_done || !auto_running)
                    begin
                        next_state = CCAC_ST_IDLE;
                        fin = 1'b1;
                        fin_idle = !busy_of(assess_mode_select,
                            auto_energy || energy_above,
                            carrier_detect);
                    end
                end
                default:
                begin
                    next_state = CCAC_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= CCAC_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // one automated window per frame; rearmed on leaving the frame
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_auto_used <= 1'b0;
            auto_energy <= 1'b0;
        end
        else
        begin
            frame_auto_used <= rx_busy && (frame_auto_used || auto_start);
            if (auto_start)
            begin
                auto_energy <= 1'b0;
            end
            else if (auto_running)
            begin
                auto_energy <= auto_energy || energy_above;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            man_energy <= 1'b0;
            man_carrier <= 1'b0;
        end
        else if (man_start)
        begin
            man_energy <= 1'b0;
            man_carrier <= 1'b0;
        end
        else if (man_running)
        begin
            man_energy <= man_energy || energy_above;
            man_carrier <= man_carrier || carrier_detect;
        end
    end

    // ------------------------------------------------------------
    // result flags
    // ------------------------------------------------------------
    // a completion in the cycle of a clear still lands
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            assess_complete_flag <= 1'b0;
            channel_idle_flag <= 1'b0;
            assess_end_irq <= 1'b0;
        end
        else
        begin
            assess_end_irq <= fin;
            if (fin)
            begin
                assess_complete_flag <= 1'b1;
                channel_idle_flag <= fin_idle;
            end
            else if (req)
            begin
                assess_complete_flag <= 1'b0;
                channel_idle_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control and threshold
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            assess_mode_select <= ccac_mode_t'(`CCAC_RST_MODE);
            channel_select <= `CCAC_RST_CHAN;
        end
        else if (wr_ctrl)
        begin
            assess_mode_select <=
                ccac_mode_t'(reg_wdata[`CCAC_MODE_HI:`CCAC_MODE_LO]);
            channel_select <= reg_wdata[`CCAC_CHAN_HI:`CCAC_CHAN_LO];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            energy_threshold_level <= `CCAC_RST_THR;
            thres_reserved <= `CCAC_RST_RSV;
        end
        else if (wr_thres)
        begin
            energy_threshold_level <= reg_wdata[`CCAC_THR_HI:`CCAC_THR_LO];
            thres_reserved <= reg_wdata[`CCAC_RSV_HI:`CCAC_RSV_LO];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] status_word = {assess_complete_flag, channel_idle_flag,
        1'b0, trx_state_in};
    // start bit always reads back low
    wire [7:0] ctrl_word = {1'b0, assess_mode_select, channel_select};
    wire [7:0] thres_word = {thres_reserved, energy_threshold_level};
    wire [7:0] rd_word =
        (reg_addr == `CCAC_OFF_STATUS) ? status_word :
        (reg_addr == `CCAC_OFF_CTRL) ? ctrl_word :
        (reg_addr == `CCAC_OFF_THRES) ? thres_word : 8'h00;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rd_word;
        end
    end

endmodule

`default_nettype wire

/* File: sim/ccac_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccac_map.svh"

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module ccac_ctrl_sva
    import ccac_pkg::*;
#(
    parameter int unsigned SYM8_CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] trx_state_in,
    input wire logic rx_listen,
    input wire logic rx_busy,
    input wire logic shr_detected,
    input wire logic carrier_detect,
    input wire logic [7:0] energy_level,
    input wire logic [4:0] channel_select,
    input wire ccac_mode_t assess_mode_select,
    input wire logic assess_end_irq
);
    wire logic ctl_wr = reg_wr && reg_addr == `CCAC_OFF_CTRL;
    wire logic req = ctl_wr && reg_wdata[7];
    wire logic mapped = reg_addr == `CCAC_OFF_STATUS ||
        reg_addr == `CCAC_OFF_CTRL || reg_addr == `CCAC_OFF_THRES;
    logic pend;
    int cnt;

    // window age since any request; pending flag cleared on leaving listen or on the irq
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend <= 1'b0;
            cnt <= 0;
        end
        else if (req)
        begin
            pend <= rx_listen;
            cnt <= 1;
        end
        else
        begin
            pend <= pend && rx_listen && !assess_end_irq;
            cnt <= cnt + 1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_irq_one_pulse: assert property (assess_end_irq |=>
        !assess_end_irq || $past(req)) else $error("irq longer than one");
    a_nolisten_done: assert property (req && !rx_listen && !rx_busy
        |=> assess_end_irq) else $error("no irq outside listen");
    a_listen_time: assert property (pend && rx_listen |->
        assess_end_irq == (cnt == SYM8_CYCLES + 2)) else $error("late irq");
    a_ctrl_write: assert property (ctl_wr |=>
        assess_mode_select == $past(reg_wdata[6:5]) &&
        channel_select == $past(reg_wdata[4:0])) else $error("ctrl wr");
    a_ctrl_stable: assert property (!ctl_wr |=>
        $stable(channel_select) && $stable(assess_mode_select))
        else $error("ctrl moved");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    a_status_read: assert property (reg_rd && reg_addr ==
        `CCAC_OFF_STATUS |=> reg_rdata[5:0] == {1'b0, $past(trx_state_in)})
        else $error("status low bits");
    a_start_reads0: assert property (reg_rd &&
        reg_addr == `CCAC_OFF_CTRL |=> !reg_rdata[7])
        else $error("start bit read");
    a_unmapped_zero: assert property (reg_rd && !mapped |=>
        reg_rdata == 8'h00) else $error("unmapped read");

    c_listen: cover property (req && rx_listen);
    c_busy: cover property (req && rx_busy);
    c_off: cover property (req && !rx_listen && !rx_busy);
endmodule
`default_nettype wire

/* File: sim/ccac_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccac_map.svh"

`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        end \
    end

module ccac_ctrl_tb;
    import ccac_pkg::*;
    localparam int unsigned SYM8 = 16;
    // marks a pulse that waits for the frame's automated window
    localparam int WAIT_AUTO = -2;
    logic core_clk, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, energy_level = 8'h00, reg_rdata;
    logic [4:0] trx_state_in = 5'h00, channel_select, st;
    logic rx_listen = 1'b0, rx_busy = 1'b0, shr_detected = 1'b0;
    logic carrier_detect = 1'b0, assess_end_irq, rd_pend = 1'b0;
    logic ed, cs, busy;
    logic [1:0] m;
    logic [3:0] t;
    ccac_mode_t assess_mode_select;
    int error_cnt = 0, checks_done = 0, since = 0, lat;
    logic [7:0] rd_q[$];
    int lat_q[$];
    logic [7:0] exp_rd;
    logic win_ok;

    ccac_ctrl #(.SYM8_CYCLES(SYM8)) u_ccac_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .trx_state_in(trx_state_in),
        .rx_listen(rx_listen), .rx_busy(rx_busy),
        .shr_detected(shr_detected), .carrier_detect(carrier_detect),
        .energy_level(energy_level), .channel_select(channel_select),
        .assess_mode_select(assess_mode_select),
        .assess_end_irq(assess_end_irq));

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // result watcher
    // ----------------------------------------------------------------
    always @(posedge core_clk)
    begin
        rd_pend <= reg_rd;
        since <= (reg_wr && reg_addr == `CCAC_OFF_CTRL && reg_wdata[7]) ?
            0 : since + 1;
    end

    always @(negedge core_clk)
    begin
        // pop once: the compare macro reads its expected value twice
        if (rd_pend)
        begin
            exp_rd = rd_q.pop_front();
            `CHK("rdata", exp_rd, reg_rdata)
        end
        if (assess_end_irq)
        begin
            lat = (lat_q.size() == 0) ? -1 : lat_q.pop_front();
            win_ok = since > 1 && since <= SYM8 + 1;
            if (lat == WAIT_AUTO)
                `CHK("irq_wait", 1'b1, win_ok)
            else
                `CHK("irq_lat", lat, since)
        end
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bounded wait until every expected pulse has been seen
    task automatic drain(input int n);
        int k;
        k = 0;
        while (lat_q.size() != 0 && k < n)
        begin
            @(negedge core_clk);
            k++;
        end
        if (lat_q.size() != 0)
        begin
            error_cnt++;
            results();
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(64344));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        `CHK("chan_rst", 5'h0B, channel_select)
        `CHK("mode_rst", CCAC_MODE_ED, assess_mode_select)
        rd(`CCAC_OFF_STATUS, 8'h00);
        rd(`CCAC_OFF_CTRL, 8'h2B);
        rd(`CCAC_OFF_THRES, 8'hC7);
        st = 5'($urandom);
        wr(`CCAC_OFF_THRES, {3'h0, st});
        rd(`CCAC_OFF_THRES, {3'h0, st});
        wr(`CCAC_OFF_STATUS, 8'hFF);
        rd(`CCAC_OFF_STATUS, 8'h00);
        rd(6'h3F, 8'h00);
        trx_state_in <= st;
        // immediate answers pulse in the cycle right after the request
        lat_q.push_back(0);
        wr(`CCAC_OFF_CTRL, 8'hD5);
        rd(`CCAC_OFF_STATUS, {3'h4, st});
        rd(`CCAC_OFF_CTRL, 8'h55);
        `CHK("chan", 5'h15, channel_select)
        rx_listen <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            m = 2'(i);
            ed = i[2];
            cs = i[3];
            t = 4'($urandom);
            busy = (m == 2'h0) ? (ed | cs) : (m == 2'h1) ? ed :
                (m == 2'h2) ? cs : (ed & cs);
            wr(`CCAC_OFF_THRES, {4'hC, t});
            energy_level <= ed ? 8'(2 * t + 1 + $urandom_range(0, 9)) :
                8'(2 * t);
            carrier_detect <= cs;
            lat_q.push_back(SYM8 + 1);
            wr(`CCAC_OFF_CTRL, {1'b1, m, 5'(i)});
            rd(`CCAC_OFF_STATUS, {3'h0, st});
            wr(`CCAC_OFF_CTRL, {1'b0, m, 5'(i)});
            drain(SYM8 * 2);
            rd(`CCAC_OFF_STATUS, {1'b1, !busy, 1'b0, st});
        end
        rx_listen <= 1'b0;
        rx_busy <= 1'b1;
        energy_level <= 8'hFF;
        carrier_detect <= 1'b1;
        @(posedge core_clk);
        shr_detected <= 1'b1;
        @(posedge core_clk);
        shr_detected <= 1'b0;
        lat_q.push_back(WAIT_AUTO);
        wr(`CCAC_OFF_CTRL, 8'hA0);
        drain(SYM8 * 2);
        lat_q.push_back(0);
        wr(`CCAC_OFF_CTRL, 8'hE0);
        drain(4);
        rd(`CCAC_OFF_STATUS, {3'h4, st});
        carrier_detect <= 1'b0;
        lat_q.push_back(0);
        wr(`CCAC_OFF_CTRL, 8'hC0);
        drain(4);
        rd(`CCAC_OFF_STATUS, {3'h6, st});
        rx_busy <= 1'b0;
        @(negedge core_clk);
        results();
    end
endmodule

bind ccac_ctrl ccac_ctrl_sva #(.SYM8_CYCLES(SYM8_CYCLES)) u_ccac_ctrl_sva (
    .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trx_state_in(trx_state_in), .rx_listen(rx_listen), .rx_busy(rx_busy),
    .shr_detected(shr_detected), .carrier_detect(carrier_detect),
    .energy_level(energy_level), .channel_select(channel_select),
    .assess_mode_select(assess_mode_select),
    .assess_end_irq(assess_end_irq));
`default_nettype wire
